// ### rtl/spi_eeprom_boot_loader.sv
// Purpose: boot sequencer loading records from an SPI EEPROM into core memories
// Assumes: straps and miso synchronous to clock_in
// Notes: payload written one byte per write strobe
// What this block does
// - low eeprom strap skips SPI boot
// - order: SPI stage, flash probe, ROM
// - any reset source restarts the sequence
// - probe reads four bytes, 16-bit address zero
// - full signature match selects 16-bit mode
// - shifted three-byte match selects 24-bit mode
// - no match abandons SPI stage
// - read records until execute record
// - unknown types skipped by length, no writes
// - type 0 I, 1 X, 2 Y, 3 execute
// - bytes one, two: length, low first
// - bytes three, four: address; payload follows
// - flash probe with 660 ns strobe low
`timescale 1ns/1ps
`default_nettype none
module spi_eeprom_boot_loader
  import spi_eeprom_boot_loader_pkg::*;
(
  // clock and resets
  input wire logic clock_in,
  input wire logic resetn_in,
  input wire logic external_reset_pin_n_in,
  input wire logic watchdog_reset_in,
  // straps
  input wire logic eeprom_select_strap_in,
  input wire logic flash_enable_strap_in,
  // spi eeprom
  input wire logic spi_miso_in,
  output logic spi_sck_out,
  output logic spi_mosi_out,
  output logic eeprom_select_out,
  output logic eeprom_select_oe_out,
  // core memories
  output logic mem_write_out,
  output logic [1:0] mem_space_out,
  output logic [15:0] mem_addr_out,
  output logic [7:0] mem_data_out,
  // handover
  output logic addr_24bit_out,
  output logic boot_exec_out,
  output logic [15:0] exec_addr_out,
  output logic rom_handover_out,
  // parallel flash probe
  output logic flash_read_strobe_n_out,
  input wire logic [7:0] flash_data_in,
  output logic [7:0] flash_probe_data_out
);

  function automatic logic [7:0] hdr_byte(input logic [1:0] idx, input logic wide,
                                          input logic probing);
    logic [23:0] a;
    a = probing ? SIG_ADDR : RECORD_ADDR;
    hdr_byte = READ_CMD;
    if (wide)
    begin
      case (idx)
        2'h1: hdr_byte = a[23:16];
        2'h2: hdr_byte = a[15:8];
        2'h3: hdr_byte = a[7:0];
        default: hdr_byte = READ_CMD;
      endcase
    end
    else
    begin
      case (idx)
        2'h1: hdr_byte = a[15:8];
        2'h2: hdr_byte = a[7:0];
        default: hdr_byte = READ_CMD;
      endcase
    end
  endfunction : hdr_byte

  logic restart;
  assign restart = !external_reset_pin_n_in || watchdog_reset_in;

  // spi byte engine
  logic spi_start;
  logic [7:0] spi_tx;
  logic busy, next_busy;
  logic sck, next_sck;
  logic [2:0] bit_cnt, next_bit_cnt;
  logic [1:0] div_cnt, next_div_cnt;
  logic [7:0] tx_sh, next_tx_sh;
  logic [7:0] rx_sh, next_rx_sh;
  logic spi_done, next_spi_done;

  always_comb
  begin
    next_busy = busy;
    next_sck = sck;
    next_bit_cnt = bit_cnt;
    next_div_cnt = div_cnt;
    next_tx_sh = tx_sh;
    next_rx_sh = rx_sh;
    next_spi_done = 1'b0;
    if (!busy)
    begin
      if (spi_start)
      begin
        next_busy = 1'b1;
        next_tx_sh = spi_tx;
        next_bit_cnt = 3'h0;
        next_div_cnt = 2'h0;
        next_sck = 1'b0;
      end
    end
    else if (div_cnt == SPI_HALF_CYCLES - 2'h1)
    begin
      next_div_cnt = 2'h0;
      if (!sck)
      begin
        next_sck = 1'b1;
        next_rx_sh = {rx_sh[6:0], spi_miso_in};
      end
      else
      begin
        next_sck = 1'b0;
        next_tx_sh = {tx_sh[6:0], 1'b0};
        next_bit_cnt = bit_cnt + 3'h1;
        if (bit_cnt == 3'h7)
        begin
          next_busy = 1'b0;
          next_spi_done = 1'b1;
        end
      end
    end
    else
    begin
      next_div_cnt = div_cnt + 2'h1;
    end
    if (restart)
    begin
      next_busy = 1'b0;
      next_sck = 1'b0;
      next_spi_done = 1'b0;
    end
  end

  always_ff @(posedge clock_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      busy <= 1'b0;
      sck <= 1'b0;
      bit_cnt <= 3'h0;
      div_cnt <= 2'h0;
      tx_sh <= 8'h00;
      rx_sh <= 8'h00;
      spi_done <= 1'b0;
    end
    else
    begin
      busy <= next_busy;
      sck <= next_sck;
      bit_cnt <= next_bit_cnt;
      div_cnt <= next_div_cnt;
      tx_sh <= next_tx_sh;
      rx_sh <= next_rx_sh;
      spi_done <= next_spi_done;
    end
  end

  assign spi_sck_out = sck;
  assign spi_mosi_out = tx_sh[7];

  // boot sequencer
  state_type state, next_state;
  logic wide, next_wide;
  logic probing, next_probing;
  logic waiting, next_waiting;
  logic [1:0] hdr_idx, next_hdr_idx;
  logic [2:0] byte_idx, next_byte_idx;
  logic [31:0] probe_buf, next_probe_buf;
  logic [7:0] rec_type, next_rec_type;
  logic [15:0] rec_len, next_rec_len;
  logic [15:0] rec_addr, next_rec_addr;
  logic [5:0] cnt, next_cnt;
  logic cs_n, next_cs_n;
  logic spi_stage, next_spi_stage;
  logic mem_wr, next_mem_wr;
  logic [1:0] mem_space, next_mem_space;
  logic [15:0] mem_addr, next_mem_addr;
  logic [7:0] mem_data, next_mem_data;
  logic exec, next_exec;
  logic [15:0] exec_addr, next_exec_addr;
  logic rom, next_rom;
  logic strobe_n, next_strobe_n;
  logic [7:0] flash_data, next_flash_data;
  logic reading;

  assign reading = (state == ST_SEND) || (state == ST_PROBE) || (state == ST_REC_HDR) ||
                   (state == ST_DATA) || (state == ST_SKIP);

  always_comb
  begin
    next_state = state;
    next_wide = wide;
    next_probing = probing;
    next_waiting = waiting;
    next_hdr_idx = hdr_idx;
    next_byte_idx = byte_idx;
    next_probe_buf = probe_buf;
    next_rec_type = rec_type;
    next_rec_len = rec_len;
    next_rec_addr = rec_addr;
    next_cnt = cnt;
    next_cs_n = cs_n;
    next_spi_stage = spi_stage;
    next_mem_wr = 1'b0;
    next_mem_space = mem_space;
    next_mem_addr = mem_addr;
    next_mem_data = mem_data;
    next_exec = exec;
    next_exec_addr = exec_addr;
    next_rom = rom;
    next_strobe_n = strobe_n;
    next_flash_data = flash_data;
    spi_start = 1'b0;
    spi_tx = (state == ST_SEND) ? hdr_byte(hdr_idx, wide, probing) : 8'h00;
    if (reading && !waiting && !busy)
    begin
      spi_start = 1'b1;
      next_waiting = 1'b1;
    end
    if (spi_done)
    begin
      next_waiting = 1'b0;
    end
    case (state)
      ST_START:
      begin
        next_wide = 1'b0;
        next_probing = 1'b1;
        next_hdr_idx = 2'h0;
        next_byte_idx = 3'h0;
        next_cnt = 6'h00;
        if (eeprom_select_strap_in)
        begin
          next_cs_n = 1'b0;
          next_spi_stage = 1'b1;
          next_state = ST_SEND;
        end
        else
        begin
          next_state = ST_FLASH;
        end
      end
      ST_SEND:
      begin
        if (spi_done)
        begin
          next_hdr_idx = hdr_idx + 2'h1;
          if (hdr_idx == (wide ? HDR_LAST_24 : HDR_LAST_16))
          begin
            next_byte_idx = 3'h0;
            next_state = probing ? ST_PROBE : ST_REC_HDR;
          end
        end
      end
      ST_PROBE:
      begin
        if (spi_done)
        begin
          next_probe_buf = {probe_buf[23:0], rx_sh};
          next_byte_idx = byte_idx + 3'h1;
          if (byte_idx == PROBE_LAST)
          begin
            next_cs_n = 1'b1;
            next_state = ST_CHECK;
          end
        end
      end
      ST_CHECK:
      begin
        next_cnt = 6'h00;
        next_probing = 1'b0;
        next_hdr_idx = 2'h0;
        if (probe_buf == BOOT_SIGNATURE)
        begin
          next_wide = 1'b0;
          next_state = ST_GAP;
        end
        else if (probe_buf[23:0] == BOOT_SIGNATURE[31:8])
        begin
          next_wide = 1'b1;
          next_state = ST_GAP;
        end
        else
        begin
          next_spi_stage = 1'b0;
          next_state = ST_FLASH;
        end
      end
      ST_GAP:
      begin
        next_cnt = cnt + 6'h01;
        if (cnt == CS_GAP_CYCLES - 6'h01)
        begin
          next_cs_n = 1'b0;
          next_state = ST_SEND;
        end
      end
      ST_REC_HDR:
      begin
        if (spi_done)
        begin
          next_byte_idx = byte_idx + 3'h1;
          case (byte_idx)
            POS_TYPE: next_rec_type = rx_sh;
            POS_LEN_LO: next_rec_len = {rec_len[15:8], rx_sh};
            POS_LEN_HI: next_rec_len = {rx_sh, rec_len[7:0]};
            POS_ADDR_LO: next_rec_addr = {rec_addr[15:8], rx_sh};
            default: next_rec_addr = {rx_sh, rec_addr[7:0]};
          endcase
          if (byte_idx == POS_ADDR_HI)
          begin
            next_byte_idx = 3'h0;
            if (rec_type == TYPE_EXEC)
            begin
              next_cs_n = 1'b1;
              next_spi_stage = 1'b0;
              next_exec = 1'b1;
              next_exec_addr = {rx_sh, rec_addr[7:0]};
              next_state = ST_EXEC;
            end
            else if (rec_len == 16'h0000)
            begin
              next_state = ST_REC_HDR;
            end
            else if (rec_type == TYPE_IMEM || rec_type == TYPE_XMEM ||
                     rec_type == TYPE_YMEM)
            begin
              next_state = ST_DATA;
            end
            else
            begin
              next_state = ST_SKIP;
            end
          end
        end
      end
      ST_DATA:
      begin
        if (spi_done)
        begin
          next_mem_wr = 1'b1;
          next_mem_space = rec_type[1:0];
          next_mem_addr = rec_addr;
          next_mem_data = rx_sh;
          next_rec_addr = rec_addr + 16'h0001;
          next_rec_len = rec_len - 16'h0001;
          if (rec_len == 16'h0001)
          begin
            next_state = ST_REC_HDR;
          end
        end
      end
      ST_SKIP:
      begin
        if (spi_done)
        begin
          next_rec_len = rec_len - 16'h0001;
          if (rec_len == 16'h0001)
          begin
            next_state = ST_REC_HDR;
          end
        end
      end
      ST_FLASH:
      begin
        next_cnt = 6'h00;
        if (flash_enable_strap_in)
        begin
          next_strobe_n = 1'b0;
          next_state = ST_STROBE;
        end
        else
        begin
          next_state = ST_ROM;
        end
      end
      ST_STROBE:
      begin
        next_cnt = cnt + 6'h01;
        if (cnt == STROBE_LOW_CYCLES - 6'h01)
        begin
          next_strobe_n = 1'b1;
          next_flash_data = flash_data_in;
          next_state = ST_ROM;
        end
      end
      ST_ROM:
      begin
        next_rom = 1'b1;
      end
      ST_EXEC:
      begin
        next_exec = 1'b1;
      end
      default:
      begin
        next_state = ST_START;
      end
    endcase
    if (restart)
    begin
      next_state = ST_START;
      next_waiting = 1'b0;
      next_cs_n = 1'b1;
      next_spi_stage = 1'b0;
      next_mem_wr = 1'b0;
      next_exec = 1'b0;
      next_rom = 1'b0;
      next_strobe_n = 1'b1;
    end
  end

  always_ff @(posedge clock_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      state <= ST_START;
      wide <= 1'b0;
      probing <= 1'b1;
      waiting <= 1'b0;
      hdr_idx <= 2'h0;
      byte_idx <= 3'h0;
      probe_buf <= 32'h00000000;
      rec_type <= 8'h00;
      rec_len <= 16'h0000;
      rec_addr <= 16'h0000;
      cnt <= 6'h00;
      cs_n <= 1'b1;
      spi_stage <= 1'b0;
      mem_wr <= 1'b0;
      mem_space <= 2'h0;
      mem_addr <= 16'h0000;
      mem_data <= 8'h00;
      exec <= 1'b0;
      exec_addr <= 16'h0000;
      rom <= 1'b0;
      strobe_n <= 1'b1;
      flash_data <= 8'h00;
    end
    else
    begin
      state <= next_state;
      wide <= next_wide;
      probing <= next_probing;
      waiting <= next_waiting;
      hdr_idx <= next_hdr_idx;
      byte_idx <= next_byte_idx;
      probe_buf <= next_probe_buf;
      rec_type <= next_rec_type;
      rec_len <= next_rec_len;
      rec_addr <= next_rec_addr;
      cnt <= next_cnt;
      cs_n <= next_cs_n;
      spi_stage <= next_spi_stage;
      mem_wr <= next_mem_wr;
      mem_space <= next_mem_space;
      mem_addr <= next_mem_addr;
      mem_data <= next_mem_data;
      exec <= next_exec;
      exec_addr <= next_exec_addr;
      rom <= next_rom;
      strobe_n <= next_strobe_n;
      flash_data <= next_flash_data;
    end
  end

  assign eeprom_select_out = cs_n;
  assign eeprom_select_oe_out = spi_stage;
  assign mem_write_out = mem_wr;
  assign mem_space_out = mem_space;
  assign mem_addr_out = mem_addr;
  assign mem_data_out = mem_data;
  assign addr_24bit_out = wide;
  assign boot_exec_out = exec;
  assign exec_addr_out = exec_addr;
  assign rom_handover_out = rom;
  assign flash_read_strobe_n_out = strobe_n;
  assign flash_probe_data_out = flash_data;

endmodule : spi_eeprom_boot_loader
`default_nettype wire

// ### rtl/spi_eeprom_boot_loader_pkg.sv
// Purpose: constants and types for the boot loader
// Assumes: 50 MHz core clock
// Notes: signature value is arbitrary
package spi_eeprom_boot_loader_pkg;
  localparam logic [7:0] READ_CMD = 8'h03;
  // arbitrary signature value, replace per product
  localparam logic [31:0] BOOT_SIGNATURE = 32'h5aa53cc3;
  localparam logic [23:0] SIG_ADDR = 24'h000000;
  localparam logic [23:0] RECORD_ADDR = 24'h000004;
  localparam logic [7:0] TYPE_IMEM = 8'h00;
  localparam logic [7:0] TYPE_XMEM = 8'h01;
  localparam logic [7:0] TYPE_YMEM = 8'h02;
  localparam logic [7:0] TYPE_EXEC = 8'h03;
  localparam logic [2:0] POS_TYPE = 3'h0;
  localparam logic [2:0] POS_LEN_LO = 3'h1;
  localparam logic [2:0] POS_LEN_HI = 3'h2;
  localparam logic [2:0] POS_ADDR_LO = 3'h3;
  localparam logic [2:0] POS_ADDR_HI = 3'h4;
  localparam logic [2:0] PROBE_LAST = 3'h3;
  localparam logic [1:0] HDR_LAST_16 = 2'h2;
  localparam logic [1:0] HDR_LAST_24 = 2'h3;
  localparam int CLK_PERIOD_NS = 20;
  localparam int STROBE_LOW_NS = 660;
  localparam logic [5:0] STROBE_LOW_CYCLES =
    6'((STROBE_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [1:0] SPI_HALF_CYCLES = 2'h2;
  localparam logic [5:0] CS_GAP_CYCLES = 6'h04;
  typedef enum logic [3:0] {
    ST_START,
    ST_SEND,
    ST_PROBE,
    ST_CHECK,
    ST_GAP,
    ST_REC_HDR,
    ST_DATA,
    ST_SKIP,
    ST_EXEC,
    ST_FLASH,
    ST_STROBE,
    ST_ROM
  } state_type;
endpackage : spi_eeprom_boot_loader_pkg

// ### verification/spi_eeprom_model.sv
// Purpose: behavioural serial eeprom on the loader spi pins
// Assumes: mode 0, read command then 16 or 24 bit address
// Notes: miso toggles whenever the part is not driving it
`timescale 1ns/1ps
`default_nettype none
module spi_eeprom_model
  import spi_eeprom_boot_loader_pkg::*;
(
  // spi pins
  input wire logic sck_in,
  input wire logic mosi_in,
  input wire logic cs_n_in,
  // part variant and data out
  input wire logic mode24_in,
  output logic miso_out
);
  logic [7:0] mem [0:63];
  logic [31:0] sr = 32'h0;
  logic [5:0] base = 6'h0;
  logic cmd_ok = 1'b0;
  int nbits = 0;
  int hdr;
  int k;
  assign hdr = mode24_in ? 32 : 24;
  assign k = nbits - hdr;
  initial miso_out = 1'b0;
  // shift in on rising sck, deselect ends the burst
  always @(posedge sck_in or posedge cs_n_in)
    if (cs_n_in)
      nbits <= 0;
    else
    begin
      sr <= {sr[30:0], mosi_in};
      nbits <= nbits + 1;
      if (nbits == hdr - 1)
      begin
        base <= 6'({sr[22:0], mosi_in});
        cmd_ok <= (mode24_in ? sr[30:23] : sr[22:15]) === READ_CMD;
      end
    end
  // msb first on falling sck
  always @(negedge sck_in or posedge cs_n_in)
    if (cs_n_in || k < 0 || !cmd_ok)
      miso_out <= ~miso_out;
    else
      miso_out <= mem[base + 6'(k / 8)][7 - k % 8];
endmodule : spi_eeprom_model
`default_nettype wire

// ### verification/spi_eeprom_boot_loader_properties.sv
// Purpose: port-level assertions for the boot loader
// Assumes: one clock domain, straps steady during boot
// Notes: bound into every loader instance
`timescale 1ns/1ps
`default_nettype none
module spi_eeprom_boot_loader_properties
  import spi_eeprom_boot_loader_pkg::*;
(
  // clock and resets
  input wire logic clock_in,
  input wire logic resetn_in,
  input wire logic external_reset_pin_n_in,
  input wire logic watchdog_reset_in,
  // strap and spi
  input wire logic eeprom_select_strap_in,
  input wire logic spi_sck_out,
  input wire logic spi_mosi_out,
  input wire logic eeprom_select_out,
  input wire logic eeprom_select_oe_out,
  // memories and handover
  input wire logic mem_write_out,
  input wire logic [1:0] mem_space_out,
  input wire logic [15:0] mem_addr_out,
  input wire logic boot_exec_out,
  input wire logic flash_read_strobe_n_out
);
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!resetn_in);
  logic [15:0] last_addr;
  logic [4:0] gap;
  logic [5:0] low_cnt;
  wire logic run = external_reset_pin_n_in && !watchdog_reset_in;
  always_ff @(posedge clock_in or negedge resetn_in)
    if (!resetn_in)
    begin
      last_addr <= 16'h0;
      gap <= 5'h1f;
      low_cnt <= 6'h0;
    end
    else
    begin
      low_cnt <= flash_read_strobe_n_out ? 6'h0 : low_cnt + 6'h1;
      last_addr <= mem_write_out ? mem_addr_out : last_addr;
      gap <= mem_write_out ? 5'h0 : (gap == 5'h1f ? gap : gap + 5'h1);
    end
  sequence boot_start;
    $rose(resetn_in) && eeprom_select_strap_in;
  endsequence
  sequence select_low;
    ##[1:2] !eeprom_select_out;
  endsequence
  strap_skip_a:
    assert property ($rose(resetn_in) && !eeprom_select_strap_in |-> eeprom_select_out [*8])
    else $error("select fell with the strap low");
  strap_boot_a:
    assert property (boot_start |-> select_low)
    else $error("spi stage did not start");
  sck_idle_a:
    assert property (eeprom_select_out |-> !spi_sck_out)
    else $error("sck high while deselected");
  mosi_hold_a:
    assert property ($rose(spi_sck_out) && run |=> $stable(spi_mosi_out))
    else $error("mosi moved while sck high");
  write_space_a:
    assert property (mem_write_out |-> mem_space_out != 2'h3 ##1 !mem_write_out)
    else $error("bad memory write pulse");
  addr_step_a:
    assert property (mem_write_out && gap < 5'h14 |-> mem_addr_out == last_addr + 16'h1)
    else $error("payload address not ascending");
  exec_stop_a:
    assert property (boot_exec_out && run |=> boot_exec_out && eeprom_select_out
      && !mem_write_out)
    else $error("activity after execute record");
  strobe_len_a:
    assert property ($rose(flash_read_strobe_n_out) |-> low_cnt == STROBE_LOW_CYCLES)
    else $error("flash strobe low time wrong");
  flash_after_a:
    assert property (!flash_read_strobe_n_out |-> eeprom_select_out && !eeprom_select_oe_out
      && !boot_exec_out)
    else $error("flash probe out of order");
  restart_halt_a:
    assert property (!run |=> eeprom_select_out && !spi_sck_out)
    else $error("restart did not stop spi");
endmodule : spi_eeprom_boot_loader_properties
bind spi_eeprom_boot_loader spi_eeprom_boot_loader_properties u_props (
  .clock_in, .resetn_in, .external_reset_pin_n_in, .watchdog_reset_in,
  .eeprom_select_strap_in, .spi_sck_out, .spi_mosi_out, .eeprom_select_out,
  .eeprom_select_oe_out, .mem_write_out, .mem_space_out, .mem_addr_out,
  .boot_exec_out, .flash_read_strobe_n_out);
`default_nettype wire

// ### verification/tb_spi_eeprom_boot_loader.sv
// Purpose: self-checking bench for the boot loader
// Assumes: eeprom model on the spi pins, select pulled up
// Notes: table rows first, then reset and restart cases
`timescale 1ns/1ps
`default_nettype none
module tb_spi_eeprom_boot_loader
  import spi_eeprom_boot_loader_pkg::*;
();
  typedef struct packed {logic sel, fl, m24, bad, rom, ex, b24;} row_type;
  localparam row_type ROWS [0:4] = '{7'b0100100, 7'b1000010, 7'b1010011, 7'b1101100,
    7'b1011100};
  localparam logic [25:0] EXP_W [0:2] = '{26'h00010a1, 26'h00011a2, 26'h20020b3};
  logic clock_in = 1'b0;
  logic resetn_in = 1'b0;
  logic ext_n = 1'b1, wdog = 1'b0, sel_strap = 1'b0, fl_strap = 1'b0, m24 = 1'b0;
  wire logic miso, sck, mosi, cs, cs_oe, wr, ex, b24, rom, strobe_n;
  wire logic [1:0] space;
  wire logic [15:0] addr, ex_addr;
  wire logic [7:0] data, probe;
  wire logic cs_n = cs_oe ? cs : 1'b1;
  int err_total = 0;
  int checks_done = 0;
  logic [25:0] wq [$];
  // signature at 0, records from 4
  logic [7:0] img [0:32] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h02, 8'h00, 8'h10,
    8'h00, 8'ha1, 8'ha2, 8'h07, 8'h01, 8'h00, 8'h55, 8'h55, 8'hee, 8'h02, 8'h01, 8'h00,
    8'h20, 8'h00, 8'hb3, 8'h01, 8'h00, 8'h00, 8'h30, 8'h00, 8'h03, 8'h00, 8'h00, 8'h34,
    8'h12};
  always #10 clock_in = ~clock_in;
  spi_eeprom_boot_loader uut (.clock_in(clock_in), .resetn_in(resetn_in),
    .external_reset_pin_n_in(ext_n), .watchdog_reset_in(wdog),
    .eeprom_select_strap_in(sel_strap), .flash_enable_strap_in(fl_strap),
    .spi_miso_in(miso), .spi_sck_out(sck), .spi_mosi_out(mosi), .eeprom_select_out(cs),
    .eeprom_select_oe_out(cs_oe), .mem_write_out(wr), .mem_space_out(space),
    .mem_addr_out(addr), .mem_data_out(data), .addr_24bit_out(b24), .boot_exec_out(ex),
    .exec_addr_out(ex_addr), .rom_handover_out(rom), .flash_read_strobe_n_out(strobe_n),
    .flash_data_in(8'h5c), .flash_probe_data_out(probe));
  spi_eeprom_model u_eeprom (.sck_in(sck), .mosi_in(mosi), .cs_n_in(cs_n),
    .mode24_in(m24), .miso_out(miso));
  always @(posedge clock_in)
    if (wr === 1'b1)
      wq.push_back({space, addr, data});
  task automatic tick(input int n);
    repeat (n) @(posedge clock_in);
    #2;
  endtask : tick
  task automatic check(input string what, input logic [25:0] seen, input logic [25:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic close_out;
    $display("checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : close_out
  task automatic start(input row_type r);
    int n;
    for (n = 0; n < 33; n++)
      u_eeprom.mem[n] = img[n];
    if (r.bad)
      u_eeprom.mem[0] = 8'h00;
    sel_strap = r.sel;
    fl_strap = r.fl;
    m24 = r.m24;
    wq.delete();
    resetn_in = 1'b0;
    tick(10);
    resetn_in = 1'b1;
  endtask : start
  task automatic finish(input row_type r);
    int n;
    for (n = 0; n < 4000 && ex !== 1'b1 && rom !== 1'b1; n++)
      tick(1);
    tick(3);
    check("limit", 26'(n >= 4000), 26'h0);
    check("exec", ex, r.ex);
    check("rom", rom, r.rom);
    check("mode24", b24, r.b24);
    check("writes", 26'(wq.size()), r.ex ? 26'h3 : 26'h0);
    for (n = 0; n < wq.size() && n < 3; n++)
      check("write", wq[n], EXP_W[n]);
    if (r.ex)
      check("exec addr", ex_addr, 26'h1234);
    if (r.rom && r.fl)
      check("probe", probe, 26'h5c);
  endtask : finish
  initial
  begin
    int k;
    for (k = 0; k < 4; k++)
      img[k] = BOOT_SIGNATURE[31 - 8 * k -: 8];
    tick(1);
    for (k = 0; k < 5; k++)
    begin
      start(ROWS[k]);
      finish(ROWS[k]);
    end
    resetn_in = 1'b0;
    tick(1);
    check("reset", {cs, cs_oe, sck, mosi, wr, ex, rom, strobe_n, b24}, 26'h102);
    // restart by watchdog, then by the pin, in mid-load
    for (k = 0; k < 2; k++)
    begin
      start(ROWS[1]);
      tick(400);
      wdog = (k == 0);
      ext_n = (k == 0);
      tick(1);
      wdog = 1'b0;
      ext_n = 1'b1;
      wq.delete();
      finish(ROWS[1]);
    end
    close_out();
  end
  initial
  begin
    #(20 * 40000);
    err_total++;
    close_out();
  end
endmodule : tb_spi_eeprom_boot_loader
`default_nettype wire
